// File: design/pulse_gen_regs.svh
// register map, field positions, reset values and divider counts of the
// four-channel pulse generator; assumes a 16-bit register port with
// byte addresses exactly as given here
`ifndef PULSE_GEN_REGS_SVH
`define PULSE_GEN_REGS_SVH

// ==========================================================
// register addresses
`define ADDR_PULSE_CONTROL 16'hc0e6
`define ADDR_PULSE_WINDOW_MAX 16'hc0e8
`define ADDR_CH0_PULSE_BEGIN 16'hc0ea
`define ADDR_CH0_PULSE_END 16'hc0ec
`define ADDR_CH1_PULSE_BEGIN 16'hc0ee
`define ADDR_CH1_PULSE_END 16'hc0f0
`define ADDR_CH2_PULSE_BEGIN 16'hc0f2
`define ADDR_CH2_PULSE_END 16'hc0f4
`define ADDR_CH3_PULSE_BEGIN 16'hc0f6
`define ADDR_CH3_PULSE_END 16'hc0f8
`define ADDR_ONESHOT_WINDOW_COUNT 16'hc0fa
`define ADDR_PULSE_STATUS 16'hc0fc

// ==========================================================
// control register fields
`define CTRL_RUN_BIT 15
`define CTRL_PRESCALE_HI 11
`define CTRL_PRESCALE_LO 9
`define CTRL_MODE_BIT 8
`define CTRL_POL_HI 7
`define CTRL_POL_LO 4
`define CTRL_EN_HI 3
`define CTRL_EN_LO 0
`define CTRL_WRITE_MASK 16'h8fff
`define COUNT_FIELD_MASK 16'h03ff
`define REG_RESET 16'h0000

// ==========================================================
// status register fields
`define STAT_RUNNING_BIT 15
`define STAT_DONE_BIT 14

// ==========================================================
// prescaler limits: core clocks per counter tick minus one
`define PRESC_WIDTH 13
`define PRESC_LIMIT_0 13'h0000
`define PRESC_LIMIT_1 13'h0001
`define PRESC_LIMIT_2 13'h0007
`define PRESC_LIMIT_3 13'h001f
`define PRESC_LIMIT_4 13'h007f
`define PRESC_LIMIT_5 13'h01ff
`define PRESC_LIMIT_6 13'h07ff
`define PRESC_LIMIT_7 13'h1fff

`endif

// File: design/pulse_gen_pkg.sv
// types shared by the pulse generator modules
// assumes pulse_gen_regs.svh for all numeric constants
package pulse_gen_pkg;

   // ==========================================================
   // basic types
   typedef logic [9:0] count_t;
   typedef logic [15:0] word_t;

   // ==========================================================
   // generator sequencing
   typedef enum logic [1:0] {
      GEN_IDLE = 2'b00,
      GEN_RUN = 2'b01,
      GEN_DONE = 2'b10
   } gen_state_e;

endpackage

// File: design/pulse_chan_if.sv
// carrier between the shared window counter and one channel comparator
// assumes one instance per channel, all on core_clk
interface pulse_chan_if;
   import pulse_gen_pkg::*;

   // ==========================================================
   // shared timing and per-channel settings
   logic running;
   count_t window_pos;
   count_t window_max;
   count_t begin_pos;
   count_t end_pos;
   logic polarity;
   logic enable;
   logic pin_level;

   modport ctrl (
      output running,
      output window_pos,
      output window_max,
      output begin_pos,
      output end_pos,
      output polarity,
      output enable,
      input pin_level
   );

   modport chan (
      input running,
      input window_pos,
      input window_max,
      input begin_pos,
      input end_pos,
      input polarity,
      input enable,
      output pin_level
   );

endinterface

// File: design/pulse_channel.sv
// one channel comparator: turns the shared window position into a pin level
// assumes the window position is on the same clock and already registered
module pulse_channel
   import pulse_gen_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   pulse_chan_if.chan ch
);

   // ==========================================================
   // active decision
   logic active;
   logic level_reg;

   // pulse active between begin and end, end beyond window holds it on unless begin equals end
   always_comb begin
      active = 1'b0;
      if (ch.running && ch.enable) begin
         if (ch.begin_pos == ch.end_pos) begin
            active = 1'b0;
         end else if (ch.end_pos > ch.window_max) begin
            active = 1'b1;
         end else begin
            active = (ch.window_pos >= ch.begin_pos) && (ch.window_pos < ch.end_pos);
         end
      end
   end

   // ==========================================================
   // pin level register
   // polarity selects active level
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         level_reg <= 1'b1;
      end else begin
         level_reg <= active ? ch.polarity : ~ch.polarity;
      end
   end

   assign ch.pin_level = level_reg;

endmodule

// File: design/pulse_gen_top.sv
// four-channel pulse generator with a shared window counter
// assumes a same-clock register port: one-cycle strobes, read data next cycle
// assumes the pins need no synchronising and no reset beyond rst_n
// rst_n is synchronous and active low; all state resets on one edge, the pin flops to one
//
// Summary of operation
// - run bit starts and stops everything
// - prescale field picks the counter tick rate
// - one-shot mode stops after programmed windows
// - continuous mode wraps window forever
// - per-channel polarity bit sets active level
// - per-channel enable bit gates output
// - ten-bit maximum sets window length
// - begin value makes channel active
// - end value makes channel inactive
// - begin equal end keeps output inactive
// - end above maximum keeps output active unless begin equals end
// - one-shot windows equal count plus one
`include "pulse_gen_regs.svh"

module pulse_gen_top
   import pulse_gen_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic [3:0] pulse_out,
   output logic gen_running
);

   // ==========================================================
   // address decode helpers

   // both strobes share one decoder; the port never asks for a wait,
   // so decoding is purely combinational and ready in the strobe cycle
   // odd and unlisted addresses land on index 15 and are ignored
   // register index: 0 control, 1 max, 2..9 begin/end pairs, 10 count,
   // 11 status, 15 unmapped
   function automatic logic [3:0] reg_index(input logic [15:0] addr);
      logic [3:0] idx;
      idx = 4'hf;
      case (addr)
         `ADDR_PULSE_CONTROL: idx = 4'h0;
         `ADDR_PULSE_WINDOW_MAX: idx = 4'h1;
         `ADDR_CH0_PULSE_BEGIN: idx = 4'h2;
         `ADDR_CH0_PULSE_END: idx = 4'h3;
         `ADDR_CH1_PULSE_BEGIN: idx = 4'h4;
         `ADDR_CH1_PULSE_END: idx = 4'h5;
         `ADDR_CH2_PULSE_BEGIN: idx = 4'h6;
         `ADDR_CH2_PULSE_END: idx = 4'h7;
         `ADDR_CH3_PULSE_BEGIN: idx = 4'h8;
         `ADDR_CH3_PULSE_END: idx = 4'h9;
         `ADDR_ONESHOT_WINDOW_COUNT: idx = 4'ha;
         `ADDR_PULSE_STATUS: idx = 4'hb;
         default: idx = 4'hf;
      endcase
      return idx;
   endfunction

   // prescale codes map to divide ratios 1, 2, 8, 32, 128, 512, 2048, 8192;
   // the limit is the last prescaler value before a tick, so a ratio of
   // one gives a tick on every core clock
   // core clocks per tick minus one for a prescale code
   function automatic logic [`PRESC_WIDTH-1:0] presc_limit(input logic [2:0] sel);
      logic [`PRESC_WIDTH-1:0] lim;
      lim = `PRESC_LIMIT_0;
      case (sel)
         3'h0: lim = `PRESC_LIMIT_0;
         3'h1: lim = `PRESC_LIMIT_1;
         3'h2: lim = `PRESC_LIMIT_2;
         3'h3: lim = `PRESC_LIMIT_3;
         3'h4: lim = `PRESC_LIMIT_4;
         3'h5: lim = `PRESC_LIMIT_5;
         3'h6: lim = `PRESC_LIMIT_6;
         default: lim = `PRESC_LIMIT_7;
      endcase
      return lim;
   endfunction

   // ==========================================================
   // register storage
   // apart from the cycle count, only the documented fields are stored; reserved bits read as zero
   // whatever software writes, so a careless write cannot set them
   // cycle count keeps all sixteen bits, but only the low ten are used
   // begin and end registers are indexed by channel number
   word_t control_reg;
   count_t window_max_reg;
   count_t begin_reg [4];
   count_t end_reg [4];
   word_t cycle_count_reg;
   word_t rdata_reg;

   logic [3:0] wr_idx;
   logic [3:0] rd_idx;
   logic ctrl_write;

   assign wr_idx = reg_index(reg_addr);
   assign rd_idx = reg_index(reg_addr);
   assign ctrl_write = reg_wr && (wr_idx == 4'h0);

   // fields are decoded straight from the stored word, so a control
   // write takes effect on the next core clock with no extra staging
   // mode and run are sampled every clock, so they can change mid-window
   // control fields
   logic run_bit;
   logic oneshot_mode;
   logic [2:0] prescale_sel;
   logic [3:0] chan_pol;
   logic [3:0] chan_en;

   assign run_bit = control_reg[`CTRL_RUN_BIT];
   assign oneshot_mode = control_reg[`CTRL_MODE_BIT];
   assign prescale_sel = control_reg[`CTRL_PRESCALE_HI:`CTRL_PRESCALE_LO];
   assign chan_pol = control_reg[`CTRL_POL_HI:`CTRL_POL_LO];
   assign chan_en = control_reg[`CTRL_EN_HI:`CTRL_EN_LO];

   // control and shared window registers; reserved bits kept at zero except in the cycle count, which stores all sixteen
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         control_reg <= `REG_RESET;
         window_max_reg <= '0;
         cycle_count_reg <= `REG_RESET;
      end else if (reg_wr) begin
         case (wr_idx)
            4'h0: control_reg <= reg_wdata & `CTRL_WRITE_MASK;
            4'h1: window_max_reg <= reg_wdata[9:0];
            4'ha: cycle_count_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // per-channel begin and end registers, index pairs from 2 upward
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            begin_reg[i] <= '0;
            end_reg[i] <= '0;
         end
      end else if (reg_wr && (wr_idx >= 4'h2) && (wr_idx <= 4'h9)) begin
         if (wr_idx[0] == 1'b0) begin
            begin_reg[2'((wr_idx - 4'h2) >> 1)] <= reg_wdata[9:0];
         end else begin
            end_reg[2'((wr_idx - 4'h2) >> 1)] <= reg_wdata[9:0];
         end
      end
   end

   // ==========================================================
   // sequencing state
   // sequence of a start, counted from the control write edge:
   //    edge one: sequencer enters run, window position still zero
   //    edge two: first tick possible, pins reflect position zero
   //    every tick: position steps, back to zero after the maximum
   // a one-shot run leaves run on the tick that closes its last window
   // and rests in done, with the counter at zero and pins inactive,
   // until software clears the run bit or writes the control again
   // gen_running follows the state register, so it lags the write by one edge
   gen_state_e state_reg;
   gen_state_e state_next;
   logic [`PRESC_WIDTH-1:0] presc_reg;
   logic tick;
   count_t window_pos_reg;
   logic window_end;
   logic [10:0] windows_done_reg;
   logic last_window;

   assign tick = (state_reg == GEN_RUN) && (presc_reg == presc_limit(prescale_sel));
   assign window_end = tick && (window_pos_reg == window_max_reg);
   assign last_window = windows_done_reg == {1'b0, cycle_count_reg[9:0]};

   // next state of the run sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         GEN_IDLE: begin
            if (run_bit) begin
               state_next = GEN_RUN;
            end
         end
         GEN_RUN: begin
            if (!run_bit) begin
               state_next = GEN_IDLE;
            end else if (oneshot_mode && window_end && last_window) begin
               state_next = GEN_DONE;
            end
         end
         GEN_DONE: begin
            // a fresh control write or clearing run rearms the sequencer
            if (!run_bit || ctrl_write) begin
               state_next = GEN_IDLE;
            end
         end
         default: state_next = GEN_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= GEN_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // the prescaler restarts on every entry into run, so the first tick
   // of a run always comes a full divide period after the start
   // changing the prescale code mid-run can stretch one tick: the
   // count compares for equality and runs on to its width if passed
   // prescaler: one tick every limit+1 core clocks while running
   // tick rate divider
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         presc_reg <= '0;
      end else if ((state_reg != GEN_RUN) || tick) begin
         presc_reg <= '0;
      end else begin
         presc_reg <= presc_reg + `PRESC_WIDTH'(1);
      end
   end

   // the position clears in the same edge that run is left, so a
   // stopped or finished generator never shows a stale position
   // lowering the maximum below the current position mid-run lets the
   // position run on to its ten-bit wrap before the window restarts
   // shared window position
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         window_pos_reg <= '0;
      end else if ((state_reg != GEN_RUN) || (state_next != GEN_RUN)) begin
         window_pos_reg <= '0;
      end else if (window_end) begin
         window_pos_reg <= '0;
      end else if (tick) begin
         window_pos_reg <= window_pos_reg + 10'h001;
      end
   end

   // the tally is one bit wider than the count field so that it never
   // wraps, and stops at the last window instead of counting past it
   // the tally clears whenever the sequencer is out of run
   // completed windows in the current run
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         windows_done_reg <= '0;
      end else if (state_reg != GEN_RUN) begin
         windows_done_reg <= '0;
      end else if (window_end && !last_window) begin
         windows_done_reg <= windows_done_reg + 11'h001;
      end
   end

   // ==========================================================
   // channels
   // one comparator per channel, each with its own carrier; the pins
   // come from flops inside the comparators, one clock behind the
   // position, so they never glitch while the compares settle
   // a disabled or stopped channel shows the inverse of its polarity
   logic [3:0] pin_level;

   for (genvar c = 0; c < 4; c++) begin : g_chan
      pulse_chan_if chan_bus ();

      assign chan_bus.running = (state_reg == GEN_RUN);
      assign chan_bus.window_pos = window_pos_reg;
      assign chan_bus.window_max = window_max_reg;
      assign chan_bus.begin_pos = begin_reg[c];
      assign chan_bus.end_pos = end_reg[c];
      assign chan_bus.polarity = chan_pol[c];
      assign chan_bus.enable = chan_en[c];
      assign pin_level[c] = chan_bus.pin_level;

      pulse_channel u_chan (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .ch(chan_bus.chan)
      );
   end

   // pins go straight out; any synchronising is left to the pad ring
   assign pulse_out = pin_level;

   // ==========================================================
   // read port
   // status is an extra read-only word beside the register map:
   // bit 15 running, bit 14 one-shot done, low ten bits the position
   // writes to it are ignored
   // reading status has no side effect on the sequencer
   word_t status_word;

   assign status_word = {(state_reg == GEN_RUN), (state_reg == GEN_DONE), 4'h0,
                         window_pos_reg};

   // read data return to zero when no read is pending, so a master that
   // samples one cycle late sees zero rather than stale data
   // the strobe and address are decoded in the same cycle they stand
   // read data registered, valid the cycle after the read strobe only
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (reg_rd) begin
         unique case (rd_idx)
            4'h0: rdata_reg <= control_reg;
            4'h1: rdata_reg <= {6'h00, window_max_reg};
            4'h2: rdata_reg <= {6'h00, begin_reg[0]};
            4'h3: rdata_reg <= {6'h00, end_reg[0]};
            4'h4: rdata_reg <= {6'h00, begin_reg[1]};
            4'h5: rdata_reg <= {6'h00, end_reg[1]};
            4'h6: rdata_reg <= {6'h00, begin_reg[2]};
            4'h7: rdata_reg <= {6'h00, end_reg[2]};
            4'h8: rdata_reg <= {6'h00, begin_reg[3]};
            4'h9: rdata_reg <= {6'h00, end_reg[3]};
            4'ha: rdata_reg <= cycle_count_reg;
            4'hb: rdata_reg <= status_word;
            default: rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata = rdata_reg;

   // running flag registered through the state register
   assign gen_running = (state_reg == GEN_RUN);

endmodule

// File: verification/pulse_gen_chk.sv
// port checker for the four-channel pulse generator
// assumes the register map header and a single core_clk domain
`include "pulse_gen_regs.svh"
module pulse_gen_chk
   import pulse_gen_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [3:0] pulse_out,
   input wire logic gen_running
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // shadow of control and settle counters
   logic ctl_wr;
   word_t ctl_reg;
   logic [1:0] quiet_reg; // stopped cycles without a control write
   logic [1:0] settle_reg; // cycles since a control write
   assign ctl_wr = reg_wr && reg_addr == `ADDR_PULSE_CONTROL;
   // control shadow
   always_ff @(posedge core_clk) begin
      if (!rst_n) ctl_reg <= `REG_RESET;
      else if (ctl_wr) ctl_reg <= reg_wdata & `CTRL_WRITE_MASK;
   end
   // saturating count while stopped
   always_ff @(posedge core_clk) begin
      if (!rst_n || ctl_wr || gen_running) quiet_reg <= 2'h0;
      else if (quiet_reg != 2'h3) quiet_reg <= quiet_reg + 2'h1;
   end
   // saturating count after a control write
   always_ff @(posedge core_clk) begin
      if (!rst_n || ctl_wr) settle_reg <= 2'h0;
      else if (settle_reg != 2'h3) settle_reg <= settle_reg + 2'h1;
   end
   // ==========================================================
   // assertions
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
   property p_ctl_read;
      reg_rd && reg_addr == `ADDR_PULSE_CONTROL |=> reg_rdata == $past(ctl_reg);
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
   property p_unmapped;
      reg_rd && (reg_addr[0] || reg_addr < 16'hc0e6 || reg_addr > 16'hc0fc)
         |=> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_start;
      ctl_wr && reg_wdata[15] |-> ##[1:2] gen_running;
   endproperty
   a_start: assert property (p_start) else $error("run bit did not start");
   property p_stop;
      ctl_wr && !reg_wdata[15] |-> ##[1:2] !gen_running;
   endproperty
   a_stop: assert property (p_stop) else $error("run bit did not stop");
   property p_hold;
      gen_running && !ctl_wr && ctl_reg[15] && !ctl_reg[8] |=> gen_running;
   endproperty
   a_hold: assert property (p_hold) else $error("continuous mode stopped");
   property p_stopped;
      quiet_reg == 2'h3 |-> pulse_out == ~ctl_reg[7:4];
   endproperty
   a_stopped: assert property (p_stopped) else $error("stopped output active");
   property p_disabled;
      settle_reg == 2'h3 |-> ((pulse_out ^ ~ctl_reg[7:4]) & ~ctl_reg[3:0]) == 4'h0;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled output active");
endmodule

bind pulse_gen_top pulse_gen_chk i_pulse_gen_chk(.core_clk(core_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pulse_out(pulse_out), .gen_running(gen_running));

// File: verification/testbench.sv
// self-checking bench for the four-channel pulse generator
// assumes the register map header; the bench acts as register master
`include "pulse_gen_regs.svh"
module testbench
   import pulse_gen_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic [3:0] pulse_out;
   logic gen_running;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   pulse_gen_top i_pulse_gen_top(.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pulse_out(pulse_out), .gen_running(gen_running));
   // ==========================================================
   // clock and hang guard
   initial forever #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // ==========================================================
   // tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // count settled cycles while a level holds, bounded
   task automatic span(input int bit_sel, input logic lvl, output int cnt);
      cnt = 0;
      for (int i = 0; i < 20000; i++) begin
         @(posedge core_clk);
         #1;
         if ((bit_sel < 4 ? pulse_out[bit_sel] : gen_running) === lvl) cnt++;
         else if (cnt > 0) break;
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 12; i++) rd(16'hc0e6 + 16'(2 * i), `REG_RESET);
      chk({12'h000, pulse_out}, 16'h000f);
      wr(`ADDR_PULSE_WINDOW_MAX, 16'h03ff);
      rd(`ADDR_PULSE_WINDOW_MAX, 16'h03ff);
      wr(`ADDR_ONESHOT_WINDOW_COUNT, 16'hffff);
      rd(`ADDR_ONESHOT_WINDOW_COUNT, 16'hffff);
      wr(`ADDR_PULSE_STATUS, 16'hffff);
      rd(`ADDR_PULSE_STATUS, 16'h0000);
      rd(16'hc0e7, 16'h0000);
      rd(16'h0000, 16'h0000);
      // window of four: ch1 empty, ch2 end past max, ch3 disabled
      wr(`ADDR_PULSE_WINDOW_MAX, 16'h0003);
      wr(`ADDR_CH0_PULSE_BEGIN, 16'h0001);
      wr(`ADDR_CH0_PULSE_END, 16'h0003);
      wr(`ADDR_CH1_PULSE_BEGIN, 16'h0002);
      wr(`ADDR_CH1_PULSE_END, 16'h0002);
      wr(`ADDR_CH2_PULSE_END, 16'h0005);
      wr(`ADDR_CH3_PULSE_BEGIN, 16'h0001);
      wr(`ADDR_CH3_PULSE_END, 16'h0003);
      wr(`ADDR_PULSE_CONTROL, 16'h8077);
      rd(`ADDR_PULSE_CONTROL, 16'h8077);
      repeat (3) @(posedge core_clk);
      for (int k = 4; k < 12; k++) begin
         @(posedge core_clk);
         #1 chk({12'h000, pulse_out},
            {12'h000, 3'b110, (k % 4) != 0 && (k % 4) != 3});
      end
      wr(`ADDR_PULSE_CONTROL, 16'h8007);
      repeat (3) @(posedge core_clk);
      for (int k = 0; k < 8; k++) begin
         @(posedge core_clk);
         #1 chk({13'h0000, pulse_out[3:1]}, 16'h0005);
      end
      wr(`ADDR_PULSE_CONTROL, 16'h0007);
      repeat (3) @(posedge core_clk);
      #1 chk({11'h000, gen_running, pulse_out}, 16'h000f);
      // one-shot runs count plus one windows
      for (int c = 0; c < 3; c++) begin
         wr(`ADDR_ONESHOT_WINDOW_COUNT, 16'(c));
         wr(`ADDR_PULSE_CONTROL, 16'h0000);
         wr(`ADDR_PULSE_CONTROL, 16'h8111);
         span(4, 1'b1, n);
         chk(16'(n), 16'(4 * (c + 1)));
         chk({12'h000, pulse_out}, 16'h000e);
      end
      rd(`ADDR_PULSE_STATUS, 16'h4000);
      // every prescale code: active time is one tick
      wr(`ADDR_PULSE_WINDOW_MAX, 16'h0001);
      wr(`ADDR_CH0_PULSE_BEGIN, 16'h0000);
      wr(`ADDR_CH0_PULSE_END, 16'h0001);
      for (int p = 0; p < 8; p++) begin
         wr(`ADDR_PULSE_CONTROL, 16'h0000);
         wr(`ADDR_PULSE_CONTROL, 16'h8011 | 16'(p << 9));
         span(0, 1'b1, n);
         chk(16'(n), p == 0 ? 16'h0001 : 16'(1 << (2 * p - 1)));
      end
      wr(`ADDR_PULSE_CONTROL, 16'h0000);
      tally_and_finish();
   end
endmodule
